// file: fpec_ctrl.sv
`default_nettype none
module fpec_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Flash array side
    input wire logic array_fault,
    output logic prog_pulse,
    output logic erase_pulse,
    output logic prog_verify_mode,
    output logic erase_verify_mode,
    output fpec_pkg::fpec_region_t erase_region,
    output fpec_pkg::fpec_state_t flash_state,
    // Interrupt
    output logic irq
);
    logic [7:0] mode_q, mode_d;
    logic [7:0] blk_q, blk_d;
    logic err_q, acc_q, fault_inj_q;
    logic [fpec_pkg::EV_W-1:0] ev_q, ev_en_q, ev_set;
    logic ack_q;
    logic wr, rd, wr_lane0, ctrl_open;
    logic [7:0] wdat;
    logic swe_next, prog_now, erase_now, fault;
    fpec_pkg::fpec_state_t state_d;
    fpec_pkg::fpec_region_t region_d;

    // One wait state: request answered on the cycle after it is first seen
    assign wr = avs_write && ack_q;
    assign rd = avs_read && ack_q;
    assign wr_lane0 = wr && avs_byteenable[0];
    assign wdat = avs_writedata[7:0];
    assign ctrl_open = acc_q;

    // Fault from the array or software injection
    assign fault = array_fault || fault_inj_q;

    // Bus handshake
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    always_comb begin
        avs_waitrequest = (avs_read || avs_write) && !ack_q;
    end

    // Next mode control value
    always_comb begin
        mode_d = mode_q;
        if (wr_lane0 && ctrl_open && avs_address == {2'b00, fpec_pkg::OFS_MODE_CTRL}) begin
            mode_d = wdat & fpec_pkg::MC_WR_MASK;
        end
        swe_next = mode_d[fpec_pkg::MC_SW_WRITE_EN];
        if (!swe_next) begin
            mode_d = 8'h00;
        end
        if (err_q) begin
            mode_d[fpec_pkg::MC_PROGRAM] = 1'b0;
            mode_d[fpec_pkg::MC_ERASE] = 1'b0;
        end
    end

    // Mode control register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= fpec_pkg::REG_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Next block select value
    always_comb begin
        blk_d = blk_q;
        if (wr_lane0 && ctrl_open && avs_address == {2'b00, fpec_pkg::OFS_BLOCK_SEL}) begin
            blk_d = wdat & fpec_pkg::BS_WR_MASK;
        end
        if ((blk_d & (blk_d - 8'h01)) != 8'h00) begin
            blk_d = 8'h00;
        end
        if (!swe_next) begin
            blk_d = 8'h00;
        end
    end

    // Block select register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            blk_q <= fpec_pkg::REG_RESET;
        end else begin
            blk_q <= blk_d;
        end
    end

    // Access enable register, reachable at all times
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= 1'b0;
        end else if (wr_lane0 && avs_address == {2'b00, fpec_pkg::OFS_ACCESS_EN}) begin
            acc_q <= wdat[fpec_pkg::AE_CTRL_ACCESS];
        end
    end

    // Software fault injection for bring-up
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_inj_q <= 1'b0;
        end else if (wr_lane0 && avs_address == fpec_pkg::OFS_FAULT_INJ) begin
            fault_inj_q <= wdat[0];
        end
    end

    // Error flag: set by a fault during program or erase, cleared only by reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_q <= 1'b0;
        end else if (fault && (prog_now || erase_now)) begin
            err_q <= 1'b1;
        end
    end

    // Operating mode decode from the registered bits
    always_comb begin
        prog_now = mode_q[fpec_pkg::MC_SW_WRITE_EN] && mode_q[fpec_pkg::MC_PROG_SETUP]
            && mode_q[fpec_pkg::MC_PROGRAM] && !err_q;
        erase_now = mode_q[fpec_pkg::MC_SW_WRITE_EN] && mode_q[fpec_pkg::MC_ERASE_SETUP]
            && mode_q[fpec_pkg::MC_ERASE] && !err_q;
        state_d = fpec_pkg::FPEC_IDLE;
        if (prog_now) begin
            state_d = fpec_pkg::FPEC_PROGRAMMING;
        end else if (erase_now) begin
            state_d = fpec_pkg::FPEC_ERASING;
        end else if (mode_q[fpec_pkg::MC_PROG_VERIFY]) begin
            state_d = fpec_pkg::FPEC_PVERIFY;
        end else if (mode_q[fpec_pkg::MC_ERASE_VERIFY]) begin
            state_d = fpec_pkg::FPEC_EVERIFY;
        end else if (mode_q[fpec_pkg::MC_PROG_SETUP]) begin
            state_d = fpec_pkg::FPEC_PSETUP;
        end else if (mode_q[fpec_pkg::MC_ERASE_SETUP]) begin
            state_d = fpec_pkg::FPEC_ESETUP;
        end
    end

    // Region decode of the one-hot block select
    always_comb begin
        region_d = '{valid: 1'b0, first: fpec_pkg::BLK0_BASE, last: fpec_pkg::BLK0_BASE};
        if (blk_q[4]) begin
            region_d = '{1'b1, fpec_pkg::BLK4_BASE, fpec_pkg::BLK4_LAST};
        end
        for (int i = 0; i < 4; i++) begin
            if (blk_q[i]) begin
                region_d.valid = 1'b1;
                region_d.first = fpec_pkg::BLK0_BASE + fpec_pkg::KB_SIZE * 16'(i);
                region_d.last = fpec_pkg::BLK0_LAST + fpec_pkg::KB_SIZE * 16'(i);
            end
        end
    end

    // Array-facing outputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prog_pulse <= 1'b0;
            erase_pulse <= 1'b0;
            prog_verify_mode <= 1'b0;
            erase_verify_mode <= 1'b0;
            erase_region <= '0;
            flash_state <= fpec_pkg::FPEC_IDLE;
        end else begin
            prog_pulse <= prog_now;
            erase_pulse <= erase_now && region_d.valid;
            prog_verify_mode <= state_d == fpec_pkg::FPEC_PVERIFY;
            erase_verify_mode <= state_d == fpec_pkg::FPEC_EVERIFY;
            erase_region <= region_d;
            flash_state <= state_d;
        end
    end

    // Events: program end, erase end, error raised, block select auto-clear
    always_comb begin
        ev_set = '0;
        ev_set[fpec_pkg::EV_PROG_DONE] = prog_pulse && !prog_now;
        ev_set[fpec_pkg::EV_ERASE_DONE] = erase_pulse && !(erase_now && region_d.valid);
        ev_set[fpec_pkg::EV_ERROR] = fault && (prog_now || erase_now) && !err_q;
        ev_set[fpec_pkg::EV_BLOCK_CLR] = wr_lane0 && ctrl_open
            && avs_address == {2'b00, fpec_pkg::OFS_BLOCK_SEL}
            && ((wdat[4:0] & (wdat[4:0] - 5'h01)) != 5'h00);
    end

    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ev_q <= '0;
        end else begin
            if (wr_lane0 && avs_address == fpec_pkg::OFS_IRQ_CLEAR) begin
                ev_q <= (ev_q & ~wdat[fpec_pkg::EV_W-1:0]) | ev_set;
            end else begin
                ev_q <= ev_q | ev_set;
            end
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ev_en_q <= '0;
        end else if (wr_lane0 && avs_address == fpec_pkg::OFS_IRQ_ENABLE) begin
            ev_en_q <= wdat[fpec_pkg::EV_W-1:0];
        end
    end

    // Level interrupt from a flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((ev_q | ev_set) & ev_en_q);
        end
    end

    // Read data, valid on the cycle waitrequest is low
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_readdata <= 32'h0000_0000;
            if ((avs_read || avs_write) && !ack_q && avs_read) begin
                unique case (avs_address)
                    {2'b00, fpec_pkg::OFS_MODE_CTRL}:
                        avs_readdata[7:0] <= ctrl_open ? mode_q : 8'h00;
                    {2'b00, fpec_pkg::OFS_STATUS}:
                        avs_readdata[fpec_pkg::ST_ERROR_FLAG] <= ctrl_open && err_q;
                    {2'b00, fpec_pkg::OFS_BLOCK_SEL}:
                        avs_readdata[7:0] <= ctrl_open ? blk_q : 8'h00;
                    {2'b00, fpec_pkg::OFS_ACCESS_EN}:
                        avs_readdata[fpec_pkg::AE_CTRL_ACCESS] <= acc_q;
                    fpec_pkg::OFS_IRQ_STATUS:
                        avs_readdata[fpec_pkg::EV_W-1:0] <= ev_q;
                    fpec_pkg::OFS_IRQ_ENABLE:
                        avs_readdata[fpec_pkg::EV_W-1:0] <= ev_en_q;
                    fpec_pkg::OFS_FAULT_INJ:
                        avs_readdata[0] <= fault_inj_q;
                    default:
                        avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    logic unused_rd;
    assign unused_rd = rd;
endmodule
`default_nettype wire

// file: fpec_pkg.sv
`default_nettype none
package fpec_pkg;
    // Register word offsets (byte addresses on the bus)
    localparam logic [3:0] OFS_MODE_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_BLOCK_SEL = 4'h8;
    localparam logic [3:0] OFS_ACCESS_EN = 4'hC;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h10;
    localparam logic [5:0] OFS_IRQ_CLEAR = 6'h14;
    localparam logic [5:0] OFS_IRQ_ENABLE = 6'h18;
    localparam logic [5:0] OFS_FAULT_INJ = 6'h1C;
    // Mode control, status and access enable field positions
    localparam int MC_PROGRAM = 0;
    localparam int MC_ERASE = 1;
    localparam int MC_PROG_VERIFY = 2;
    localparam int MC_ERASE_VERIFY = 3;
    localparam int MC_PROG_SETUP = 4;
    localparam int MC_ERASE_SETUP = 5;
    localparam int MC_SW_WRITE_EN = 6;
    localparam int ST_ERROR_FLAG = 7;
    localparam int AE_CTRL_ACCESS = 7;
    // Writable masks and reset values
    localparam logic [7:0] MC_WR_MASK = 8'h7F;
    localparam logic [7:0] BS_WR_MASK = 8'h1F;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Interrupt event bits
    localparam int EV_PROG_DONE = 0;
    localparam int EV_ERASE_DONE = 1;
    localparam int EV_ERROR = 2;
    localparam int EV_BLOCK_CLR = 3;
    localparam int EV_W = 4;
    // Block address ranges
    localparam logic [15:0] BLK0_BASE = 16'h0000;
    localparam logic [15:0] BLK0_LAST = 16'h03FF;
    localparam logic [15:0] BLK3_LAST = 16'h0FFF;
    localparam logic [15:0] BLK4_BASE = 16'h1000;
    localparam logic [15:0] BLK4_LAST = 16'h4FFF;
    localparam logic [15:0] KB_SIZE = 16'h0400;

    typedef enum logic [2:0] {
        FPEC_IDLE, FPEC_ESETUP, FPEC_PSETUP, FPEC_EVERIFY, FPEC_PVERIFY,
        FPEC_ERASING, FPEC_PROGRAMMING
    } fpec_state_t;

    // Target erase region handed to the array
    typedef struct packed {
        logic valid;
        logic [15:0] first;
        logic [15:0] last;
    } fpec_region_t;
endpackage
`default_nettype wire

// file: fpec_ctrl_props.sv
`default_nettype none
module fpec_ctrl_props (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Array side
    input wire logic prog_pulse,
    input wire logic erase_pulse,
    input wire logic prog_verify_mode,
    input wire logic erase_verify_mode,
    input wire fpec_pkg::fpec_region_t erase_region,
    input wire fpec_pkg::fpec_state_t flash_state
);
    logic ae_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Mirror of the access enable bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ae_q <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 6'h0C) begin
            ae_q <= avs_writedata[7];
        end
    end
    // Accepted read of one address
    sequence rd_ack(logic [5:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    // Accepted mode write with write enable low
    sequence swe_off_wr;
        avs_write && !avs_waitrequest && avs_byteenable[0] && ae_q && avs_address == 6'h00
            && !avs_writedata[6];
    endsequence
    a_upper_bytes_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("upper read bytes not zero");
    a_mode_top_zero: assert property (rd_ack(6'h00) |-> !avs_readdata[7])
        else $error("mode top bit not zero");
    a_status_low_zero: assert property (rd_ack(6'h04) |-> avs_readdata[6:0] == 7'h00)
        else $error("status low bits not zero");
    a_block_top_zero: assert property (rd_ack(6'h08) |-> avs_readdata[7:5] == 3'h0)
        else $error("block top bits not zero");
    a_enable_low_zero: assert property (rd_ack(6'h0C) |-> avs_readdata[6:0] == 7'h00)
        else $error("enable low bits not zero");
    a_blocked_read_zero: assert property (!ae_q && avs_read && !avs_waitrequest && avs_address < 6'h0C |-> avs_readdata == 32'h0000_0000)
        else $error("blocked register read not zero");
    a_swe_off_idle: assert property (swe_off_wr |=> ##1 (!prog_pulse && !erase_pulse && !prog_verify_mode && !erase_verify_mode && !erase_region.valid && flash_state == fpec_pkg::FPEC_IDLE))
        else $error("activity left after write enable cleared");
    a_region_range: assert property (erase_region.valid |-> {erase_region.first, erase_region.last} inside {32'h0000_03FF, 32'h0400_07FF, 32'h0800_0BFF, 32'h0C00_0FFF, 32'h1000_4FFF})
        else $error("erase region outside block map");
    a_erase_has_block: assert property (erase_pulse |-> erase_region.valid)
        else $error("erase without selected block");
endmodule
bind fpec_ctrl fpec_ctrl_props fpec_ctrl_props_i (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .prog_pulse(prog_pulse),
    .erase_pulse(erase_pulse), .prog_verify_mode(prog_verify_mode),
    .erase_verify_mode(erase_verify_mode), .erase_region(erase_region), .flash_state(flash_state));
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic array_fault = 1'b0;
    logic [31:0] avs_readdata;
    logic [31:0] rdq;
    logic avs_waitrequest, prog_pulse, erase_pulse, prog_verify_mode, erase_verify_mode, irq;
    fpec_pkg::fpec_region_t erase_region;
    fpec_pkg::fpec_state_t flash_state;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    fpec_ctrl fpec_ctrl_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .array_fault(array_fault), .prog_pulse(prog_pulse),
        .erase_pulse(erase_pulse), .prog_verify_mode(prog_verify_mode),
        .erase_verify_mode(erase_verify_mode), .erase_region(erase_region),
        .flash_state(flash_state), .irq(irq));
    // Clock of 40 ns period
    always #20 clk = ~clk;
    // Verdict and end of run
    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    // Compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h00_0000, d};
        // Only the hang guard ends a wait that never sees waitrequest low
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rdq, {24'h00_0000, exp});
    endtask
    // Let the written value reach the outputs
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    logic [7:0] modes [4] = '{8'h60, 8'h50, 8'h48, 8'h44};
    logic [2:0] sts [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    logic [1:0] vfy [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        wr(6'h00, 8'h7F);
        rd(6'h00, 8'h00);
        wr(6'h0C, 8'hFF);
        rd(6'h0C, 8'h80);
        rd(6'h00, 8'h00);
        $display("test access done");
        wr(6'h00, 8'h3F);
        rd(6'h00, 8'h00);
        wr(6'h08, 8'h01);
        rd(6'h08, 8'h00);
        rd(6'h20, 8'h00);
        $display("test write enable done");
        for (int i = 0; i < 4; i++) begin
            wr(6'h00, modes[i]);
            rd(6'h00, modes[i]);
            settle();
            chk({29'h0000_0000, flash_state}, {29'h0000_0000, sts[i]});
            chk({30'h0000_0000, prog_verify_mode, erase_verify_mode}, {30'h0000_0000, vfy[i]});
        end
        wr(6'h00, 8'h40);
        settle();
        chk({29'h0000_0000, flash_state}, 32'h0000_0000);
        $display("test modes done");
        wr(6'h00, 8'h50);
        wr(6'h00, 8'h51);
        settle();
        chk({31'h0000_0000, prog_pulse}, 32'h0000_0001);
        repeat (20) @(posedge clk);
        #1;
        chk({31'h0000_0000, prog_pulse}, 32'h0000_0001);
        wr(6'h00, 8'h50);
        settle();
        chk({31'h0000_0000, prog_pulse}, 32'h0000_0000);
        rd(6'h10, 8'h01);
        wr(6'h18, 8'h0F);
        settle();
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(6'h14, 8'h01);
        settle();
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(6'h00, 8'h41);
        settle();
        chk({31'h0000_0000, prog_pulse}, 32'h0000_0000);
        $display("test program done");
        wr(6'h00, 8'h60);
        for (int i = 0; i < 5; i++) begin
            wr(6'h08, 8'h01 << i);
            rd(6'h08, 8'h01 << i);
            settle();
            chk({erase_region.first, erase_region.last}, (i < 4) ? {16'(i * 1024), 16'(i * 1024 + 1023)} : 32'h1000_4FFF);
        end
        wr(6'h00, 8'h62);
        settle();
        chk({31'h0000_0000, erase_pulse}, 32'h0000_0001);
        wr(6'h00, 8'h60);
        settle();
        chk({31'h0000_0000, erase_pulse}, 32'h0000_0000);
        wr(6'h08, 8'h03);
        rd(6'h08, 8'h00);
        rd(6'h10, 8'h0A);
        wr(6'h08, 8'h10);
        wr(6'h00, 8'h00);
        rd(6'h08, 8'h00);
        $display("test erase done");
        wr(6'h00, 8'h50);
        wr(6'h00, 8'h51);
        array_fault <= 1'b1;
        repeat (3) @(posedge clk);
        array_fault <= 1'b0;
        rd(6'h04, 8'h80);
        settle();
        chk({31'h0000_0000, prog_pulse}, 32'h0000_0000);
        // Status is only ever read; the flag stays sticky
        rd(6'h04, 8'h80);
        $display("test error done");
        print_verdict();
    end
endmodule
`default_nettype wire
